// [rtl/eeprom_host_pkg.sv]
// constants for the parallel eeprom host controller
// assumes a 20 MHz system clock and synchronous pin inputs
package eeprom_host_pkg;
	localparam int CLK_MHZ = 20;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int PAGE_BYTES = 32;
	localparam int OFFS_W = 5;
	localparam int POLL_BIT = 7;
	// strobe low time in ns and cycles (min, rounded up)
	localparam int STROBE_NS = 150;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	// read access time ns, rounded up
	localparam int ACCESS_NS = 200;
	localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
	// page load gap min (us, longest, round down) and max (us, least, round up)
	localparam int GAP_MIN_US = 10;
	localparam int GAP_MIN_CYC = GAP_MIN_US * CLK_MHZ - 1;
	localparam int GAP_MAX_US = 100;
	localparam int GAP_MAX_CYC = GAP_MAX_US * CLK_MHZ + 1;
	// write cycle 10 ms, init inhibit 20 ms
	localparam int WCYC_MS = 10;
	localparam int WCYC_CYC = WCYC_MS * 1000 * CLK_MHZ;
	localparam int INIT_MS = 20;
	localparam int INIT_CYC = INIT_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 20;
endpackage : eeprom_host_pkg

// [rtl/page_buffer.sv]
// page staging memory for the eeprom host controller
// assumes one writer and one reader port, same clock
module page_buffer
	import eeprom_host_pkg::*;
#(
	parameter int DEPTH = PAGE_BYTES,
	parameter int AW = OFFS_W,
	parameter int DW = DATA_W
) (
	input wire logic clk_sys,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [DW-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData
);
	logic [DW-1:0] mem [DEPTH];

	// refuse a depth that the address cannot reach
	if (DEPTH > 2**AW || DEPTH < 1) begin : g_depth
		$error("depth does not fit address");
	end

	// registered read, plain write
	always_ff @(posedge clk_sys) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule : page_buffer

// [rtl/eeprom_host_ctrl.sv]
// host controller driving a parallel eeprom through its pins
// assumes pins synchronous to clk_sys and an external wire resolver
// Summary of operation
// RULE1 - device drives data when write strobe high, select and gate low
// RULE2 - data lines float whenever select or gate is high
// RULE3 - write starts only with select and strobe low, gate high
// RULE4 - address taken at the later falling edge of strobe or select
// RULE5 - data taken at the earlier rising edge of strobe or select
// RULE6 - byte write self-erases and programs within 10 ms
// RULE7 - page mode loads 1 to 32 bytes, one 10 ms cycle
// RULE8 - page chosen by address bits 5 to 12 at first strobe
// RULE9 - bits 0 to 4 pick byte in page, any order
// RULE10 - host starts next load within 10 us of strobe rise
// RULE11 - after last byte strobe stays high 100 us before programming
// RULE12 - only loaded bytes of the page are rewritten
// RULE13 - polling read returns inverted bit 7 until done
// RULE14 - no writes below supply trip level
// RULE15 - writes ignored 5 to 20 ms after power-up
// RULE16 - no write while gate low or select or strobe high
// RULE17 - strobe pulses under 20 ns start nothing
// RULE18 - status pin low during write cycle, open drain
// RULE19 - select high deselects the device
// RULE20 - during programming only polling reads are served
module eeprom_host_ctrl
	import eeprom_host_pkg::*;
#(
	parameter int WRITE_CYCLES = WCYC_CYC,
	parameter int INIT_CYCLES = INIT_CYC
) (
	// system
	input wire logic clk_sys,
	input wire logic rst,
	// user requests
	input wire logic reqRead,
	input wire logic reqWrite,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [DATA_W-1:0] reqData,
	input wire logic reqLast,
	output logic reqReady,
	output logic rdValid,
	output logic [DATA_W-1:0] rdData,
	output logic writeDone,
	output logic busy,
	// device pins
	output logic [ADDR_W-1:0] address_lines,
	input wire logic [DATA_W-1:0] dataIn,
	output logic [DATA_W-1:0] dataOut,
	output logic dataOe_n,
	output logic chipSel_n,
	output logic outGate_n,
	output logic writeStrobe_n,
	input wire logic readyBusy_n
);
	// refuse counts that the counters cannot hold
	if (WRITE_CYCLES < 2 || INIT_CYCLES < 2) begin : g_small
		$error("counts too small");
	end
	if (WRITE_CYCLES >= 2**CNT_W || INIT_CYCLES >= 2**CNT_W) begin : g_wide
		$error("counts too wide");
	end

	typedef enum logic [6:0] {
		S_INIT = 7'h01, S_IDLE = 7'h02, S_READ = 7'h04, S_WLOW = 7'h08,
		S_GAP = 7'h10, S_PROG = 7'h20, S_POLL = 7'h40
	} state_type;

	state_type state, next_state;
	logic [CNT_W-1:0] count, next_count;
	logic [CNT_W-1:0] progCount, next_progCount;
	logic [ADDR_W-1:0] next_address_lines;
	logic [ADDR_W-OFFS_W-1:0] pageSel, next_pageSel;
	logic [DATA_W-1:0] next_dataOut, next_rdData;
	logic [ADDR_W-1:0] lastAddr, next_lastAddr;
	logic next_dataOe_n, next_chipSel_n, next_outGate_n, next_writeStrobe_n;
	logic next_rdValid, next_writeDone, pageLast, next_pageLast;
	logic bufWr;
	logic [DATA_W-1:0] bufData;

	// copy of the page being loaded; read port gives the last byte for polling
	page_buffer #(.DEPTH(PAGE_BYTES), .AW(OFFS_W), .DW(DATA_W)) shadow (
		.clk_sys(clk_sys),
		.wrEn(bufWr),
		.wrAddr(reqAddr[OFFS_W-1:0]),
		.wrData(reqData),
		.rdAddr(lastAddr[OFFS_W-1:0]),
		.rdData(bufData)
	);

	// request handshake
	always_comb begin
		reqReady = (state == S_IDLE) || (state == S_GAP && count < CNT_W'(GAP_MIN_CYC - 4)
			&& !pageLast);
		busy = (state == S_PROG) || (state == S_POLL) || !readyBusy_n;
		bufWr = reqReady && reqWrite && !(state == S_IDLE && reqRead);
	end

	// sequencer
	always_comb begin
		next_state = state;
		next_count = count;
		next_progCount = progCount;
		next_address_lines = address_lines;
		next_pageSel = pageSel;
		next_dataOut = dataOut;
		next_rdData = rdData;
		next_lastAddr = lastAddr;
		next_dataOe_n = dataOe_n;
		next_chipSel_n = chipSel_n;
		next_outGate_n = outGate_n;
		next_writeStrobe_n = writeStrobe_n;
		next_rdValid = 1'b0;
		next_writeDone = 1'b0;
		next_pageLast = pageLast;
		unique case (state)
			// RULE15 init inhibit wait
			S_INIT: begin
				next_count = count + 1'b1;
				if (count == CNT_W'(INIT_CYCLES - 1)) begin
					next_state = S_IDLE;
					next_count = '0;
				end
			end
			S_IDLE: begin
				next_count = '0;
				if (reqRead) begin
					// RULE1 select and gate low
					next_address_lines = reqAddr;
					next_chipSel_n = 1'b0;
					next_outGate_n = 1'b0;
					next_state = S_READ;
				end else if (reqWrite) begin
					// RULE3 gate high, then strobe
					// RULE8 page taken on first load
					next_address_lines = reqAddr;
					next_pageSel = reqAddr[ADDR_W-1:OFFS_W];
					next_dataOut = reqData;
					next_dataOe_n = 1'b0;
					next_outGate_n = 1'b1;
					next_chipSel_n = 1'b0;
					next_writeStrobe_n = 1'b0;
					next_lastAddr = reqAddr;
					next_pageLast = reqLast;
					next_state = S_WLOW;
				end
			end
			S_READ: begin
				// RULE2 release gate after sampling
				next_count = count + 1'b1;
				if (count == CNT_W'(ACCESS_CYC)) begin
					next_rdData = dataIn;
					next_rdValid = 1'b1;
					next_chipSel_n = 1'b1;
					next_outGate_n = 1'b1;
					next_state = S_IDLE;
				end
			end
			S_WLOW: begin
				// RULE17 strobe held well over 20 ns
				next_count = count + 1'b1;
				if (count == CNT_W'(STROBE_CYC - 1)) begin
					// RULE5 strobe rise latches data
					next_writeStrobe_n = 1'b1;
					next_count = '0;
					next_state = S_GAP;
				end
			end
			S_GAP: begin
				next_count = count + 1'b1;
				if (reqReady && reqWrite) begin
					// RULE9 offset varies, page fixed
					// RULE10 next load inside min gap
					next_address_lines = {pageSel, reqAddr[OFFS_W-1:0]};
					next_dataOut = reqData;
					next_writeStrobe_n = 1'b0;
					next_lastAddr = {pageSel, reqAddr[OFFS_W-1:0]};
					next_pageLast = reqLast;
					next_count = '0;
					next_state = S_WLOW;
				end else if (count == CNT_W'(GAP_MIN_CYC - 4)) begin
					next_dataOe_n = 1'b1;
					next_chipSel_n = 1'b1;
				end else if (count == CNT_W'(GAP_MAX_CYC)) begin
					// RULE11 strobe high past max gap
					next_progCount = '0;
					next_count = '0;
					next_state = S_PROG;
				end
			end
			S_PROG: begin
				// RULE6 RULE7 wait until done or the first poll at or past one write cycle, polling every 256 counts
				// RULE20 no strobes meanwhile
				next_dataOe_n = 1'b1;
				next_chipSel_n = 1'b1;
				next_progCount = progCount + 1'b1;
				if (progCount[7:0] == 8'hff) begin
					next_address_lines = lastAddr;
					next_chipSel_n = 1'b0;
					next_outGate_n = 1'b0;
					next_count = '0;
					next_state = S_POLL;
				end
			end
			S_POLL: begin
				// RULE13 poll bit 7 against last data
				// RULE18 status pin also watched
				next_count = count + 1'b1;
				next_progCount = progCount + 1'b1;
				if (count == CNT_W'(ACCESS_CYC)) begin
					next_chipSel_n = 1'b1;
					next_outGate_n = 1'b1;
					if ((dataIn[POLL_BIT] == bufData[POLL_BIT] && readyBusy_n)
						|| progCount >= CNT_W'(WRITE_CYCLES)) begin
						next_writeDone = 1'b1;
						next_state = S_IDLE;
					end else begin
						next_state = S_PROG;
					end
				end
			end
			default: next_state = S_INIT;
		endcase
	end

	// state registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= S_INIT;
			count <= '0;
			progCount <= '0;
			address_lines <= '0;
			pageSel <= '0;
			dataOut <= '0;
			rdData <= '0;
			lastAddr <= '0;
			dataOe_n <= 1'b1;
			chipSel_n <= 1'b1;
			outGate_n <= 1'b1;
			writeStrobe_n <= 1'b1;
			rdValid <= 1'b0;
			writeDone <= 1'b0;
			pageLast <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			progCount <= next_progCount;
			address_lines <= next_address_lines;
			pageSel <= next_pageSel;
			dataOut <= next_dataOut;
			rdData <= next_rdData;
			lastAddr <= next_lastAddr;
			dataOe_n <= next_dataOe_n;
			chipSel_n <= next_chipSel_n;
			outGate_n <= next_outGate_n;
			writeStrobe_n <= next_writeStrobe_n;
			rdValid <= next_rdValid;
			writeDone <= next_writeDone;
			pageLast <= next_pageLast;
		end
	end
endmodule : eeprom_host_ctrl

// [verif/eeprom_dev_model.sv]
// pin-level model of the parallel eeprom facing the controller
// assumes pins sampled on clk_sys; a released wire shows its inverted last level
module eeprom_dev_model #(
	parameter int BUSY_CYC = 300,
	parameter int GAP_CYC = 2000,
	parameter int INIT_CYC = 8,
	parameter bit SUPPLY_OK = 1'b1
) (
	// host pins, resolved wire and status
	input wire logic clk_sys,
	input wire logic [12:0] addr,
	input wire logic [7:0] hostData,
	input wire logic hostOe_n,
	input wire logic cs_n,
	input wire logic og_n,
	input wire logic ws_n,
	output logic [7:0] dataWire,
	output logic rdyBusy_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [8192];
	logic [7:0] page [32];
	logic [31:0] loaded = 32'h0;
	logic [12:0] latchA;
	logic [7:0] pageSel, dat, last, prevWire = 8'h00;
	logic prevWr = 1'b0, loading = 1'b0;
	int gap = 0, bsy = 0, initLeft = INIT_CYC;
	// writes blocked on low supply and during power-up wait
	// a strobe counts only when seen low at a clock edge
	wire wr = !cs_n && !ws_n && og_n && SUPPLY_OK && initLeft == 0;
	wire rd = !cs_n && !og_n && ws_n;
	initial foreach (mem[i]) mem[i] = 8'hff;
	assign dataWire = !hostOe_n ? hostData : !rd ? ~prevWire
		: bsy > 0 ? {~last[7], 7'h2a} : mem[addr];
	assign rdyBusy_n = !(bsy > 0);
	always @(posedge clk_sys) begin
		prevWr <= wr;
		prevWire <= dataWire;
		if (initLeft > 0) initLeft <= initLeft - 1;
		if (bsy > 0) begin
			bsy <= bsy - 1;
		end else if (wr) begin
			dat <= dataWire;
			if (!prevWr) latchA <= addr;
			if (!prevWr && !loading) pageSel <= addr[12:5];
		end else if (prevWr) begin
			page[latchA[4:0]] <= dat;
			loaded[latchA[4:0]] <= 1'b1;
			last <= dat;
			loading <= 1'b1;
			gap <= 0;
		end else if (loading && gap < GAP_CYC) begin
			gap <= gap + 1;
		end else if (loading) begin
			for (int i = 0; i < 32; i++) if (loaded[i]) mem[{pageSel, i[4:0]}] <= page[i];
			loaded <= 32'h0;
			loading <= 1'b0;
			bsy <= BUSY_CYC;
		end
	end
endmodule : eeprom_dev_model

// [verif/eeprom_host_ctrl_sva.sv]
// checker on the controller handshake and device pins
// assumes it is bound to the controller top, reset active high
module eeprom_host_ctrl_chk
	import eeprom_host_pkg::*;
(
	// watched ports
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reqRead,
	input wire logic reqReady,
	input wire logic rdValid,
	input wire logic busy,
	input wire logic [ADDR_W-1:0] address_lines,
	input wire logic [DATA_W-1:0] dataOut,
	input wire logic dataOe_n,
	input wire logic chipSel_n,
	input wire logic outGate_n,
	input wire logic writeStrobe_n,
	input wire logic readyBusy_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// pin and handshake relations
	chk_read_answer: assert property (reqRead && reqReady |-> ##[6:7] rdValid)
		else $error("read answer late");
	chk_read_pulse: assert property (rdValid |=> !rdValid)
		else $error("read pulse long");
	chk_gate_float: assert property (!outGate_n |-> dataOe_n)
		else $error("host drives in read");
	chk_write_mode: assert property (!writeStrobe_n |-> !chipSel_n && outGate_n)
		else $error("bad write mode");
	chk_strobe_width: assert property ($fell(writeStrobe_n) |-> !writeStrobe_n [*3])
		else $error("strobe too short");
	chk_pins_hold: assert property (!writeStrobe_n && !$fell(writeStrobe_n) |->
		$stable(address_lines) && $stable(dataOut)) else $error("pins moved in strobe");
	chk_busy_flag: assert property (!readyBusy_n |-> writeStrobe_n && !reqReady)
		else $error("write activity while device busy");
	chk_init_wait: assert property ($fell(rst) |-> !reqReady [*8])
		else $error("ready during init");
endmodule : eeprom_host_ctrl_chk
bind eeprom_host_ctrl eeprom_host_ctrl_chk chk (.clk_sys, .rst, .reqRead, .reqReady, .rdValid,
	.busy, .address_lines, .dataOut, .dataOe_n, .chipSel_n, .outGate_n, .writeStrobe_n, .readyBusy_n);

// [verif/parallel_eeprom_write_read_ctrl_test.sv]
// self-checking bench for the eeprom host controller
// assumes the device model resolves the shared data wire
module parallel_eeprom_write_read_ctrl_test
	import eeprom_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [12:0] a; logic [7:0] d;} row_type;
	row_type rows [3] = '{'{13'h0000, 8'ha5}, '{13'h1fff, 8'h3c}, '{13'h0abc, 8'h80}};
	logic clk_sys = 0, rst = 1, reqRead = 0, reqWrite = 0, reqLast = 0;
	logic [12:0] reqAddr = 13'h0000, address_lines;
	logic [7:0] reqData = 8'h00, rdData, dataIn, dataOut;
	logic reqReady, rdValid, writeDone, busy, dataOe_n, chipSel_n, outGate_n, writeStrobe_n;
	logic readyBusy_n;
	int fail_count = 0, tests_run = 0;
	always #25 clk_sys = ~clk_sys;
	eeprom_host_ctrl #(.WRITE_CYCLES(600), .INIT_CYCLES(10)) dut (.clk_sys, .rst, .reqRead,
		.reqWrite, .reqAddr, .reqData, .reqLast, .reqReady, .rdValid, .rdData, .writeDone, .busy,
		.address_lines, .dataIn, .dataOut, .dataOe_n, .chipSel_n, .outGate_n, .writeStrobe_n,
		.readyBusy_n);
	eeprom_dev_model dev (.clk_sys, .addr(address_lines), .hostData(dataOut), .hostOe_n(dataOe_n),
		.cs_n(chipSel_n), .og_n(outGate_n), .ws_n(writeStrobe_n), .dataWire(dataIn),
		.rdyBusy_n(readyBusy_n));
	task summarize;
		$display("mismatches %0d of %0d checks", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	task cmp8(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t data %h expected %h", $time, g, e);
		end
	endtask : cmp8
	task cmp1(input logic g, input logic e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t flag %b expected %b", $time, g, e);
		end
	endtask : cmp1
	// bounded wait for a flag seen between edges
	task automatic waitfor(ref logic s);
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (s !== 1'b1 && n < 4000);
		if (n >= 4000) cmp1(1'b0, 1'b1);
		if (n >= 4000) summarize();
	endtask : waitfor
	// request held until an edge that sees ready
	task req(input logic w, input logic [12:0] a, input logic [7:0] d, input logic l);
		@(posedge clk_sys);
		reqRead <= !w;
		reqWrite <= w;
		reqAddr <= a;
		reqData <= d;
		reqLast <= l;
		waitfor(reqReady);
		@(posedge clk_sys);
		reqRead <= 1'b0;
		reqWrite <= 1'b0;
	endtask : req
	task rdc(input logic [12:0] a, input logic [7:0] e);
		req(1'b0, a, 8'h00, 1'b0);
		waitfor(rdValid);
		cmp8(rdData, e);
	endtask : rdc
	task reset_dut;
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		cmp1(reqReady, 1'b0);
		cmp1(chipSel_n, 1'b1);
	endtask : reset_dut
	// table rows, then page, refusal and mid-run reset
	initial begin
		reset_dut();
		rdc(13'h0100, 8'hff);
		foreach (rows[i]) begin
			req(1'b1, rows[i].a, rows[i].d, 1'b1);
			waitfor(writeDone);
			rdc(rows[i].a, rows[i].d);
		end
		req(1'b1, 13'h1e45, 8'h11, 1'b0);
		req(1'b1, 13'h0001, 8'h22, 1'b0);
		req(1'b1, 13'h001f, 8'h33, 1'b1);
		repeat (2100) @(negedge clk_sys);
		cmp1(busy, 1'b1);
		cmp1(reqReady, 1'b0);
		waitfor(writeDone);
		rdc(13'h1e45, 8'h11);
		rdc(13'h1e41, 8'h22);
		rdc(13'h1e5f, 8'h33);
		rdc(13'h1e42, 8'hff);
		reset_dut();
		rdc(13'h0abc, 8'h80);
		summarize();
	end
endmodule : parallel_eeprom_write_read_ctrl_test
